// >>> hw/tlw_defines.svh
`ifndef TLW_DEFINES_SVH
`define TLW_DEFINES_SVH

// Register selector values carried by the pointer byte.
`define TLW_PTR_READING 2'h0
`define TLW_PTR_SETUP 2'h1
`define TLW_PTR_RELEASE 2'h2
`define TLW_PTR_TRIP 2'h3

// Power-on contents.
`define TLW_SETUP_RESET 8'h00
`define TLW_TRIP_RESET 16'h5000
`define TLW_RELEASE_RESET 16'h4B00
`define TLW_READING_RESET 11'h000

// Fixed upper four bits of the 7-bit bus address.
`define TLW_ADDR_PREFIX 4'h9

// Zero padding below the justified values.
`define TLW_READING_PAD 5'h00
`define TLW_LIMIT_PAD 7'h00

// Byte framing on the bus: eight data bits per byte.
`define TLW_BITS_PER_BYTE 4'h8

// Consecutive trip results required per fault count code.
`define TLW_FAULT_NEED_0 3'h1
`define TLW_FAULT_NEED_1 3'h2
`define TLW_FAULT_NEED_2 3'h4
`define TLW_FAULT_NEED_3 3'h6

`endif

// >>> hw/tlw_pkg.sv
package tlw_pkg;

  // Setup byte: bit 0 shutdown, bit 1 mode, bit 2 polarity, bits 4:3 fault count.
  typedef struct packed {
    logic [2:0] reserved;
    logic [1:0] fault_count_select;
    logic alarm_polarity;
    logic alarm_mode_select;
    logic shutdown;
  } tlw_setup_t;

  typedef struct packed {
    logic [8:0] trip_threshold;
    logic [8:0] release_threshold;
  } tlw_limits_t;

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_RX,
    BUS_ACK,
    BUS_TX,
    BUS_MACK
  } tlw_bus_state_t;

  typedef enum logic [1:0] {
    RX_ADDR,
    RX_POINTER,
    RX_DATA
  } tlw_rx_kind_t;

endpackage

// >>> hw/tlw_alarm_engine.sv
`timescale 1ns/1ps
`include "tlw_defines.svh"

module tlw_alarm_engine (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_conv_done,
  input wire logic [8:0] i_reading,
  input wire tlw_pkg::tlw_limits_t i_limits,
  input wire logic i_mode_int,
  input wire logic [1:0] i_fault_sel,
  input wire logic i_read_clear,
  output logic o_active
);

  function automatic logic [2:0] fault_need(input logic [1:0] code);
    case (code)
      2'h0: fault_need = `TLW_FAULT_NEED_0;
      2'h1: fault_need = `TLW_FAULT_NEED_1;
      2'h2: fault_need = `TLW_FAULT_NEED_2;
      default: fault_need = `TLW_FAULT_NEED_3;
    endcase
  endfunction

  logic [2:0] fault_cnt;
  logic watch_low;
  logic int_flag;

  wire over_trip = $signed(i_reading) > $signed(i_limits.trip_threshold);
  wire under_release = $signed(i_reading) < $signed(i_limits.release_threshold);
  wire fault = watch_low ? under_release : over_trip;
  wire [2:0] cnt_inc = fault_cnt + 3'h1;
  wire qualified = i_conv_done & fault & (cnt_inc >= fault_need(i_fault_sel));

  wire [2:0] next_fault_cnt = !i_conv_done ? fault_cnt : (fault && !qualified) ? cnt_inc : 3'h0;
  wire next_watch_low = watch_low ^ qualified;
  // interrupt latched until read.
  // A new event in the clearing cycle wins over the read.
  wire next_int_flag = (qualified & i_mode_int) | (int_flag & ~i_read_clear);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      fault_cnt <= 3'h0;
      watch_low <= 1'b0;
      int_flag <= 1'b0;
    end else begin
      fault_cnt <= next_fault_cnt;
      watch_low <= next_watch_low;
      int_flag <= next_int_flag;
    end
  end

  assign o_active = i_mode_int ? int_flag : watch_low;

endmodule

// >>> hw/thermal_limit_watchdog.sv
// Overview of operation
// - Reading returns two bytes, host takes both.
// - Reading left-justified, five low bits zero.
// - Reading is signed, eighth-degree per count.
// - Trip and release limits are read/write.
// - Compare each finished conversion, update alarm.
// - Limits hold nine signed bits, left-justified.
// - Compare only top nine reading bits.
// - Limit reads give sixteen bits, seven zero.
// - Setup bit 2 selects alarm polarity.
// - Setup bit 1 selects interrupt mode.
// - Comparator asserts above trip, clears below release.
// - Comparator alarm unaffected by reads, shutdown.
// - Interrupt alarm holds until any read.
// - Alarm needs consecutive trip results.
// - Fault code maps to 1, 2, 4, 6.
// - Shutdown stops conversions, bus and alarm hold.
// - Trip limit resets to 80 degrees.
// - Release limit resets to 75 degrees.
`timescale 1ns/1ps
`include "tlw_defines.svh"

module thermal_limit_watchdog (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic [2:0] i_addr_sel,
  input wire logic i_conv_done,
  input wire logic [10:0] i_conv_result,
  output logic o_conv_enable,
  output logic o_alarm_pin_o,
  output logic o_alarm_pin_oe
);

  // Bus pins come from the host's domain and pass two flip-flops first.
  logic scl_s1;
  logic scl_s2;
  logic scl_d;
  logic sda_s1;
  logic sda_s2;
  logic sda_d;
  logic [2:0] addr_s1;
  logic [2:0] addr_s2;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
      addr_s1 <= 3'h0;
      addr_s2 <= 3'h0;
    end else begin
      scl_s1 <= i_scl;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= i_sda;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      addr_s1 <= i_addr_sel;
      addr_s2 <= addr_s1;
    end
  end

  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop_cond = scl_s2 & scl_d & ~sda_d & sda_s2;

  // Register state.
  tlw_pkg::tlw_setup_t setup;
  tlw_pkg::tlw_limits_t limits;
  logic [10:0] reading;

  // Bus engine state.
  tlw_pkg::tlw_bus_state_t st;
  tlw_pkg::tlw_rx_kind_t kind;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] txsh;
  logic [15:0] tx_word;
  logic byte_idx;
  logic rw;
  logic mack_ok;
  logic [1:0] pointer;
  logic [7:0] msb_hold;
  logic sda_oe;
  logic read_clear;

  tlw_pkg::tlw_bus_state_t next_st;
  tlw_pkg::tlw_rx_kind_t next_kind;
  logic [3:0] next_bit_cnt;
  logic [7:0] next_shreg;
  logic [7:0] next_txsh;
  logic [15:0] next_tx_word;
  logic next_byte_idx;
  logic next_rw;
  logic next_mack_ok;
  logic [1:0] next_pointer;
  logic [7:0] next_msb_hold;
  logic next_sda_oe;
  logic next_read_clear;
  tlw_pkg::tlw_setup_t next_setup;
  tlw_pkg::tlw_limits_t next_limits;

  wire [15:0] reading_word = {reading, `TLW_READING_PAD};
  wire [15:0] trip_word = {limits.trip_threshold, `TLW_LIMIT_PAD};
  wire [15:0] release_word = {limits.release_threshold, `TLW_LIMIT_PAD};
  // The one-byte setup register repeats for every byte the host clocks in.
  wire [15:0] setup_word = {setup, setup};

  wire sel_reading = pointer == `TLW_PTR_READING;
  wire sel_setup = pointer == `TLW_PTR_SETUP;
  wire sel_release = pointer == `TLW_PTR_RELEASE;
  wire sel_trip = pointer == `TLW_PTR_TRIP;

  wire [15:0] read_word = sel_reading ? reading_word :
                          sel_setup ? setup_word :
                          sel_release ? release_word : trip_word;

  wire addr_hit = shreg[7:1] == {`TLW_ADDR_PREFIX, addr_s2};
  wire byte_full = bit_cnt == `TLW_BITS_PER_BYTE;
  wire [7:0] next_tx_byte = byte_idx ? tx_word[7:0] : tx_word[15:8];

  always_comb begin
    next_st = st;
    next_kind = kind;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_txsh = txsh;
    next_tx_word = tx_word;
    next_byte_idx = byte_idx;
    next_rw = rw;
    next_mack_ok = mack_ok;
    next_pointer = pointer;
    next_msb_hold = msb_hold;
    next_sda_oe = sda_oe;
    next_read_clear = 1'b0;
    next_setup = setup;
    next_limits = limits;
    if (start_cond) begin
      next_st = tlw_pkg::BUS_RX;
      next_kind = tlw_pkg::RX_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe = 1'b0;
    end else if (stop_cond) begin
      next_st = tlw_pkg::BUS_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (st)
        tlw_pkg::BUS_RX: begin
          if (scl_rise && !byte_full) begin
            next_shreg = {shreg[6:0], sda_s2};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && byte_full) begin
            next_bit_cnt = 4'h0;
            case (kind)
              tlw_pkg::RX_ADDR: begin
                if (addr_hit) begin
                  next_rw = shreg[0];
                  next_read_clear = shreg[0];
                  next_kind = tlw_pkg::RX_POINTER;
                  next_sda_oe = 1'b1;
                  next_st = tlw_pkg::BUS_ACK;
                end else begin
                  next_st = tlw_pkg::BUS_IDLE;
                end
              end
              tlw_pkg::RX_POINTER: begin
                next_pointer = shreg[1:0];
                next_kind = tlw_pkg::RX_DATA;
                next_byte_idx = 1'b0;
                next_sda_oe = 1'b1;
                next_st = tlw_pkg::BUS_ACK;
              end
              default: begin
                next_sda_oe = 1'b1;
                next_st = tlw_pkg::BUS_ACK;
                if (!byte_idx) begin
                  if (sel_setup) begin
                    next_setup = shreg;
                  end else begin
                    next_msb_hold = shreg;
                    next_byte_idx = 1'b1;
                  end
                end else begin
                  // host writes limits.
                  // Both bytes commit together so no half-written limit is compared.
                  if (sel_trip) begin
                    next_limits.trip_threshold = {msb_hold, shreg[7]};
                  end else if (sel_release) begin
                    next_limits.release_threshold = {msb_hold, shreg[7]};
                  end
                  next_byte_idx = 1'b0;
                end
              end
            endcase
          end
        end
        tlw_pkg::BUS_ACK: begin
          if (scl_fall) begin
            if (rw) begin
              next_tx_word = read_word;
              next_txsh = read_word[15:8];
              next_sda_oe = ~read_word[15];
              next_bit_cnt = 4'h1;
              next_byte_idx = 1'b1;
              next_st = tlw_pkg::BUS_TX;
            end else begin
              next_sda_oe = 1'b0;
              next_bit_cnt = 4'h0;
              next_st = tlw_pkg::BUS_RX;
            end
          end
        end
        tlw_pkg::BUS_TX: begin
          if (scl_fall) begin
            if (byte_full) begin
              next_sda_oe = 1'b0;
              next_st = tlw_pkg::BUS_MACK;
            end else begin
              next_sda_oe = ~txsh[6];
              next_txsh = {txsh[6:0], 1'b0};
              next_bit_cnt = bit_cnt + 4'h1;
            end
          end
        end
        tlw_pkg::BUS_MACK: begin
          if (scl_rise) begin
            next_mack_ok = ~sda_s2;
          end else if (scl_fall) begin
            if (mack_ok) begin
              next_txsh = next_tx_byte;
              next_sda_oe = ~next_tx_byte[7];
              next_bit_cnt = 4'h1;
              next_byte_idx = ~byte_idx;
              next_st = tlw_pkg::BUS_TX;
            end else begin
              next_st = tlw_pkg::BUS_IDLE;
            end
          end
        end
        default: begin
          next_st = tlw_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st <= tlw_pkg::BUS_IDLE;
      kind <= tlw_pkg::RX_ADDR;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      txsh <= 8'h00;
      tx_word <= 16'h0000;
      byte_idx <= 1'b0;
      rw <= 1'b0;
      mack_ok <= 1'b0;
      pointer <= `TLW_PTR_READING;
      msb_hold <= 8'h00;
      sda_oe <= 1'b0;
      read_clear <= 1'b0;
    end else begin
      st <= next_st;
      kind <= next_kind;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      txsh <= next_txsh;
      tx_word <= next_tx_word;
      byte_idx <= next_byte_idx;
      rw <= next_rw;
      mack_ok <= next_mack_ok;
      pointer <= next_pointer;
      msb_hold <= next_msb_hold;
      sda_oe <= next_sda_oe;
      read_clear <= next_read_clear;
    end
  end

  wire [15:0] trip_reset = `TLW_TRIP_RESET;
  wire [15:0] release_reset = `TLW_RELEASE_RESET;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      setup <= `TLW_SETUP_RESET;
      limits.trip_threshold <= trip_reset[15:7];
      limits.release_threshold <= release_reset[15:7];
    end else begin
      setup <= next_setup;
      limits <= next_limits;
    end
  end

  wire conv_accept = i_conv_done & ~setup.shutdown;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      reading <= `TLW_READING_RESET;
    end else if (conv_accept) begin
      reading <= i_conv_result;
    end
  end

  logic alarm_active;

  tlw_alarm_engine u_alarm (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_conv_done(conv_accept),
    .i_reading(i_conv_result[10:2]),
    .i_limits(limits),
    .i_mode_int(setup.alarm_mode_select),
    .i_fault_sel(setup.fault_count_select),
    .i_read_clear(read_clear),
    .o_active(alarm_active)
  );

  wire alarm_level = setup.alarm_polarity ? alarm_active : ~alarm_active;

  // Both pins are open drain: they only ever pull low.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_sda_o <= 1'b0;
      o_sda_oe <= 1'b0;
      o_alarm_pin_o <= 1'b0;
      o_alarm_pin_oe <= 1'b0;
      o_conv_enable <= 1'b1;
    end else begin
      o_sda_o <= 1'b0;
      o_sda_oe <= sda_oe;
      o_alarm_pin_o <= 1'b0;
      o_alarm_pin_oe <= ~alarm_level;
      o_conv_enable <= ~setup.shutdown;
    end
  end

endmodule

// >>> dv/tlw_host_model.sv
`timescale 1ns/1ps
module tlw_host_model #(
  parameter logic [6:0] ADDR = 7'h4D
) (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_rel
);
  initial begin
    o_scl = 1'h1;
    o_sda_rel = 1'h1;
  end
  // Each bit cell is entered 20 ns into the low phase of SCL.
  task automatic bit_io(input logic b, output logic s);
    o_sda_rel = b;
    #60 o_scl = 1'h1;
    s = i_sda;
    #80 o_scl = 1'h0;
    #20;
  endtask
  task automatic start();
    if (!o_scl) begin
      o_sda_rel = 1'h1;
      #60 o_scl = 1'h1;
      #40;
    end
    o_sda_rel = 1'h0;
    #40 o_scl = 1'h0;
    #20;
  endtask
  task automatic stop();
    o_sda_rel = 1'h0;
    #60 o_scl = 1'h1;
    #40 o_sda_rel = 1'h1;
    #40;
  endtask
  task automatic put(input logic [7:0] b, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'h1, nak);
  endtask
  task automatic get(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'h1, b[i]);
    bit_io(last, s);
  endtask
  task automatic wr(input logic [1:0] p, input logic [15:0] d, input int n, output logic nak);
    logic a0, a1, a2, a3;
    a2 = 1'h0;
    a3 = 1'h0;
    start();
    put({ADDR, 1'h0}, a0);
    put({6'h00, p}, a1);
    if (n > 0) put(d[15:8], a2);
    if (n > 1) put(d[7:0], a3);
    stop();
    nak = a0 | a1 | a2 | a3;
  endtask
  task automatic rd(input logic setp, input logic [1:0] p, output logic [15:0] d);
    logic a;
    if (setp) begin
      start();
      put({ADDR, 1'h0}, a);
      put({6'h00, p}, a);
    end
    start();
    put({ADDR, 1'h1}, a);
    get(1'h0, d[15:8]);
    get(1'h1, d[7:0]);
    stop();
  endtask
  task automatic probe(input logic [6:0] a, output logic nak);
    start();
    put({a, 1'h0}, nak);
    stop();
  endtask
endmodule

// >>> dv/tlw_asserts.sv
`timescale 1ns/1ps
module tlw_asserts (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_conv_done,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic o_conv_enable,
  input wire logic o_alarm_pin_o,
  input wire logic o_alarm_pin_oe
);
  logic [3:0] quiet;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Cycles since the bus side last pulled SDA, saturating; register effects follow an ACK.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || (!o_sda_oe && quiet != 4'hF)) quiet <= (i_rst_n ? quiet + 4'h1 : 4'hF);
    else if (o_sda_oe) quiet <= 4'h0;
  end
  // The registered count lags by one cycle.
  // A setup write lands as the ACK starts, so an ACK that is still driven must count as recent.
  wire [3:0] quiet_now = o_sda_oe ? 4'h0 : quiet;
  a_sda_o_zero: assert property (o_sda_o == 1'h0) else $error("sda data not low");
  a_pin_o_zero: assert property (o_alarm_pin_o == 1'h0) else $error("pin data not low");
  a_reset_vals: assert property ($rose(i_rst_n) |-> !o_alarm_pin_oe && !o_sda_oe && o_conv_enable)
    else $error("bad state after reset");
  a_sda_low_phase: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("sda moved while scl high");
  a_sda_high_stable: assert property (i_scl && $past(i_scl, 3) |-> $stable(o_sda_oe))
    else $error("sda unstable in high phase");
  a_alarm_cause: assert property ($changed(o_alarm_pin_oe) && quiet_now > 4'h8 |-> $past(i_conv_done, 2))
    else $error("alarm moved without conversion");
  a_conv_en_cause: assert property ($changed(o_conv_enable) |-> quiet_now < 4'h8)
    else $error("conv enable moved without write");
  a_conv_gate: assert property (!o_conv_enable && !$past(o_conv_enable) && i_conv_done && quiet_now > 4'h8
    |=> ##1 $stable(o_alarm_pin_oe)) else $error("conversion taken in shutdown");
  c_alarm: cover property ($rose(o_alarm_pin_oe));
  c_ack: cover property ($rose(o_sda_oe));
  c_shut: cover property ($fell(o_conv_enable));
endmodule
bind thermal_limit_watchdog tlw_asserts u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(i_scl),
  .i_conv_done(i_conv_done), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
  .o_conv_enable(o_conv_enable), .o_alarm_pin_o(o_alarm_pin_o), .o_alarm_pin_oe(o_alarm_pin_oe));

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic i_mclk, i_rst_n, i_conv_done, scl, sda, sda_rel, sda_oe, alarm_oe, conv_en, pol, nak;
  logic [10:0] i_conv_result;
  logic [15:0] d;
  int bad_count, tests_run, cyc;
  int need [4] = '{1, 2, 4, 6};
  assign sda = sda_rel & ~sda_oe;
  thermal_limit_watchdog DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda),
    .o_sda_o(), .o_sda_oe(sda_oe), .i_addr_sel(3'h5), .i_conv_done(i_conv_done),
    .i_conv_result(i_conv_result), .o_conv_enable(conv_en), .o_alarm_pin_o(),
    .o_alarm_pin_oe(alarm_oe));
  tlw_host_model host (.i_sda(sda), .o_scl(scl), .o_sda_rel(sda_rel));
  initial begin
    i_mclk = 1'h0;
    forever #5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // The pin is pulled up, so its level is the inverse of the enable.
  task automatic al(input logic act);
    chk({15'h0000, ~alarm_oe}, {15'h0000, pol ? act : ~act});
  endtask
  task automatic conv(input logic [10:0] r);
    @(negedge i_mclk);
    i_conv_done = 1'h1;
    i_conv_result = r;
    @(negedge i_mclk);
    i_conv_done = 1'h0;
    repeat (4) @(negedge i_mclk);
  endtask
  task automatic setup(input logic [7:0] v);
    host.wr(2'h1, {v, 8'h00}, 1, nak);
    pol = v[2];
    chk(nak, 16'h0000);
  endtask
  task automatic t_reset();
    host.rd(1'h0, 2'h0, d);
    chk(d, 16'h0000);
    host.rd(1'h1, 2'h3, d);
    chk(d, 16'h5000);
    host.rd(1'h1, 2'h2, d);
    chk(d, 16'h4B00);
    host.rd(1'h1, 2'h1, d);
    chk(d, 16'h0000);
    al(1'h0);
    chk(conv_en, 16'h0001);
    host.probe(7'h48, nak);
    chk(nak, 16'h0001);
    $display("reset test done");
  endtask
  task automatic t_format();
    logic [10:0] r [3] = '{11'h649, 11'h3F8, 11'h7FF};
    logic [2:0] act = 3'h2;
    for (int i = 0; i < 3; i++) begin
      conv(r[i]);
      host.rd(1'h1, 2'h0, d);
      chk(d, {r[i], 5'h00});
      chk({7'h00, d[15:7]}, {7'h00, r[i][10:2]});
      al(act[i]);
    end
    $display("format test done");
  endtask
  task automatic t_limits();
    host.wr(2'h3, 16'h19FF, 2, nak);
    host.wr(2'h3, 16'h7F00, 1, nak);
    host.rd(1'h1, 2'h3, d);
    chk(d, 16'h1980);
    host.wr(2'h2, 16'h1000, 2, nak);
    host.rd(1'h1, 2'h2, d);
    chk(d, 16'h1000);
    $display("limits test done");
  endtask
  task automatic t_queue();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      setup({3'h0, c, c[0], 2'h0});
      repeat (need[i] - 1) conv(11'h0D0);
      al(1'h0);
      conv(11'h0D0);
      al(1'h1);
      repeat (need[i] - 1) conv(11'h07C);
      al(1'h1);
      conv(11'h07C);
      al(1'h0);
    end
    $display("queue test done");
  endtask
  task automatic t_restart();
    setup(8'h08);
    conv(11'h0D0);
    conv(11'h0CF);
    conv(11'h0D0);
    al(1'h0);
    conv(11'h0D0);
    al(1'h1);
    conv(11'h07C);
    conv(11'h080);
    conv(11'h07C);
    al(1'h1);
    conv(11'h07C);
    al(1'h0);
    $display("restart test done");
  endtask
  task automatic t_int();
    setup(8'h02);
    conv(11'h0D0);
    conv(11'h0D0);
    al(1'h1);
    host.rd(1'h0, 2'h0, d);
    al(1'h0);
    conv(11'h0D0);
    al(1'h0);
    conv(11'h07C);
    al(1'h1);
    host.rd(1'h0, 2'h0, d);
    al(1'h0);
    $display("interrupt test done");
  endtask
  task automatic t_shut();
    setup(8'h00);
    conv(11'h0D0);
    al(1'h1);
    setup(8'h01);
    chk(conv_en, 16'h0000);
    conv(11'h07C);
    host.rd(1'h1, 2'h0, d);
    chk(d, 16'h1A00);
    host.rd(1'h1, 2'h1, d);
    chk(d, 16'h0101);
    al(1'h1);
    setup(8'h00);
    conv(11'h07C);
    al(1'h0);
    $display("shutdown test done");
  endtask
  initial begin
    i_rst_n = 1'h0;
    i_conv_done = 1'h0;
    i_conv_result = 11'h000;
    pol = 1'h0;
    bad_count = 0;
    tests_run = 0;
    cyc = 0;
    repeat (16) @(negedge i_mclk);
    i_rst_n = 1'h1;
    repeat (8) @(negedge i_mclk);
    t_reset();
    t_format();
    t_limits();
    t_queue();
    t_restart();
    t_int();
    t_shut();
    summarize();
  end
endmodule
